// *** hw/dma_request_mask_status_cmds.sv ***
// Request, mask, status and temporary registers of a four-channel DMA
// controller, with the five special commands, reached by I/O strobes.
// Assumes strobes, address, data and requests are asynchronous pins, and
// terminal count and memory-to-memory cycle marks come from sys_clk logic.
`timescale 1ns/1ps
`include "dma_regs_defs.svh"
module dma_request_mask_status_cmds
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host I/O port
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [`ADDR_W-1:0] io_addr,
  input wire logic [7:0] peripheral_data_bus_in,
  output logic [7:0] peripheral_data_bus_out,
  output logic peripheral_data_bus_oe,
  // Channel requests and transfer events
  input wire logic [3:0] ext_request,
  input wire logic [3:0] terminal_count,
  input wire logic m2m_first_cycle,
  input wire logic m2m_second_cycle,
  // Transfer engine view
  output logic [3:0] channel_service_request,
  output logic service_active,
  output logic [1:0] service_channel,
  output logic byte_high,
  output logic master_clear_pulse
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic rd_meta_ff, rd_sync_ff, rd_prev_ff;
  logic wr_meta_ff, wr_sync_ff, wr_prev_ff;
  logic [`ADDR_W-1:0] addr_meta_ff, addr_sync_ff;
  logic [7:0] data_meta_ff, data_sync_ff;
  logic [3:0] req_meta_ff, req_sync_ff;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_meta_ff <= 1'b1;
      rd_sync_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      wr_meta_ff <= 1'b1;
      wr_sync_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
      addr_meta_ff <= 5'h00;
      addr_sync_ff <= 5'h00;
      data_meta_ff <= 8'h00;
      data_sync_ff <= 8'h00;
      req_meta_ff <= 4'h0;
      req_sync_ff <= 4'h0;
    end
    else
    begin
      rd_meta_ff <= io_read_strobe_n;
      rd_sync_ff <= rd_meta_ff;
      rd_prev_ff <= rd_sync_ff;
      wr_meta_ff <= io_write_strobe_n;
      wr_sync_ff <= wr_meta_ff;
      wr_prev_ff <= wr_sync_ff;
      addr_meta_ff <= io_addr;
      addr_sync_ff <= addr_meta_ff;
      data_meta_ff <= peripheral_data_bus_in;
      data_sync_ff <= data_meta_ff;
      req_meta_ff <= ext_request;
      req_sync_ff <= req_meta_ff;
    end
  end

  // ****************************************************************
  // Access decode
  // ****************************************************************
  logic rd_go, wr_go, any_go, mclr;
  assign rd_go = rd_prev_ff && !rd_sync_ff;
  assign wr_go = wr_prev_ff && !wr_sync_ff;
  assign any_go = rd_go || wr_go;
  // Special commands fire on either strobe; the data bus is not looked at.
  assign mclr = any_go && (addr_sync_ff == `OFS_MASTER_CLEAR);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] mask_ff, nxt_mask;
  logic [3:0] soft_req_ff, nxt_soft_req;
  logic [3:0] pending_ff;
  logic [3:0] tc_flags_ff;
  logic [7:0] temp_ff;
  logic byte_high_ff;
  logic mclr_ff;
  logic [1:0] sel;
  mode_store_if ms ();

  assign sel = data_sync_ff[`SEL_MSB:`SEL_LSB];

  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_go && addr_sync_ff == `OFS_MASK_SINGLE)
      nxt_mask[sel] = data_sync_ff[`VALUE_BIT];
    else if (wr_go && addr_sync_ff == `OFS_MASK_ALL)
      nxt_mask = data_sync_ff[3:0];
    else if (any_go && addr_sync_ff == `OFS_CLR_MASK)
      nxt_mask = 4'h0;
    // Terminal count without autoinitialize wins over a same-cycle write.
    nxt_mask = nxt_mask | (terminal_count & ~ms.autoinit);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      mask_ff <= `MASK_RESET;
    else
      mask_ff <= nxt_mask;
  end

  always_comb
  begin
    nxt_soft_req = soft_req_ff & ~terminal_count;
    if (wr_go && addr_sync_ff == `OFS_SOFT_REQUEST)
      nxt_soft_req[sel] = data_sync_ff[`VALUE_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      soft_req_ff <= 4'h0;
    else
      soft_req_ff <= nxt_soft_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      pending_ff <= 4'h0;
    else
      pending_ff <= req_sync_ff;
  end

  // A terminal count in the same cycle as the status read is kept.
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      tc_flags_ff <= 4'h0;
    else if (rd_go && addr_sync_ff == `OFS_STATUS)
      tc_flags_ff <= terminal_count;
    else
      tc_flags_ff <= tc_flags_ff | terminal_count;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      temp_ff <= 8'h00;
    else if (m2m_first_cycle)
      temp_ff <= data_sync_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
      byte_high_ff <= 1'b0;
    else if (any_go && addr_sync_ff == `OFS_CLR_BYTE_PTR)
      byte_high_ff <= 1'b0;
    else if (any_go && addr_sync_ff == `OFS_SET_BYTE_PTR)
      byte_high_ff <= 1'b1;
    else if (any_go && addr_sync_ff <= `OFS_ADDR_COUNT_LAST)
      byte_high_ff <= !byte_high_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mclr_ff <= 1'b0;
    else
      mclr_ff <= mclr;
  end

  // ****************************************************************
  // Mode store
  // ****************************************************************
  assign ms.wr = wr_go && addr_sync_ff == `OFS_MODE;
  assign ms.wr_data = data_sync_ff;
  assign ms.rd_advance = rd_go && addr_sync_ff == `OFS_MODE;
  assign ms.clr_cnt = any_go && addr_sync_ff == `OFS_CLR_MODE_CNT;

  mode_store u_mode_store
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .master_clear(mclr),
    .ms(ms.store)
  );

  // ****************************************************************
  // Read path and data bus drive
  // ****************************************************************
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic rd_oe_ff;

  always_comb
  begin
    case (addr_sync_ff)
      `OFS_STATUS: nxt_rd_data = {pending_ff, tc_flags_ff};
      `OFS_SOFT_REQUEST: nxt_rd_data = {`UPPER_ONES, soft_req_ff};
      `OFS_MASK_ALL: nxt_rd_data = {`UPPER_ONES, mask_ff};
      `OFS_MODE: nxt_rd_data = ms.rd_data;
      default: nxt_rd_data = `UNDEF_READ;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rd_data_ff <= 8'h00;
    else if (rd_go)
      rd_data_ff <= nxt_rd_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_oe_ff <= 1'b0;
    end
    else
    begin
      rd_oe_ff <= !rd_sync_ff && (rd_go || rd_oe_ff);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      peripheral_data_bus_out <= 8'h00;
      peripheral_data_bus_oe <= 1'b0;
    end
    else if (m2m_second_cycle)
    begin
      peripheral_data_bus_out <= temp_ff;
      peripheral_data_bus_oe <= 1'b1;
    end
    else
    begin
      peripheral_data_bus_out <= rd_go ? nxt_rd_data : rd_data_ff;
      peripheral_data_bus_oe <= !rd_sync_ff && (rd_go || rd_oe_ff);
    end
  end

  // ****************************************************************
  // Transfer engine arbitration
  // ****************************************************************
  logic [3:0] eff_req;
  dma_pkg::engine_state_t state_ff;
  dma_pkg::chan_t chan_ff, nxt_chan;

  assign eff_req = (pending_ff & ~mask_ff) | soft_req_ff;

  always_comb
  begin
    nxt_chan = 2'h0;
    for (int i = 3; i >= 0; i--)
      if (eff_req[i])
        nxt_chan = 2'(i);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || mclr)
    begin
      state_ff <= dma_pkg::ENG_IDLE;
      chan_ff <= 2'h0;
    end
    else
    begin
      case (state_ff)
        dma_pkg::ENG_IDLE:
          if (eff_req != 4'h0)
          begin
            state_ff <= dma_pkg::ENG_SERVING;
            chan_ff <= nxt_chan;
          end
        dma_pkg::ENG_SERVING:
          if (terminal_count[chan_ff])
            state_ff <= dma_pkg::ENG_IDLE;
        default:
          state_ff <= dma_pkg::ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      channel_service_request <= 4'h0;
    else
      channel_service_request <= eff_req;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      service_active <= 1'b0;
      service_channel <= 2'h0;
      byte_high <= 1'b0;
      master_clear_pulse <= 1'b0;
    end
    else
    begin
      service_active <= state_ff == dma_pkg::ENG_SERVING;
      service_channel <= chan_ff;
      byte_high <= byte_high_ff;
      master_clear_pulse <= mclr_ff;
    end
  end
endmodule : dma_request_mask_status_cmds

// *** include/dma_regs_defs.svh ***
// Register offsets, field positions and reset values of the DMA request,
// mask and status register block.
// Assumes the five-bit I/O offset is already decoded to this block.
`ifndef DMA_REGS_DEFS_SVH
`define DMA_REGS_DEFS_SVH

// ****************************************************************
// Register and command offsets
// ****************************************************************
`define ADDR_W 5
`define OFS_ADDR_COUNT_LAST 5'h07
`define OFS_STATUS 5'h08
`define OFS_SOFT_REQUEST 5'h09
`define OFS_MASK_SINGLE 5'h0A
`define OFS_MODE 5'h0B
`define OFS_MASK_ALL 5'h0F
`define OFS_CLR_BYTE_PTR 5'h10
`define OFS_SET_BYTE_PTR 5'h11
`define OFS_MASTER_CLEAR 5'h12
`define OFS_CLR_MASK 5'h13
`define OFS_CLR_MODE_CNT 5'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SEL_LSB 0
`define SEL_MSB 1
`define VALUE_BIT 2
`define MODE_AUTOINIT_BIT 4
`define UPPER_ONES 4'hF
`define MASK_RESET 4'hF
`define UNDEF_READ 8'hFF

`endif

// *** include/dma_pkg.sv ***
// Types used by the transfer engine of the DMA register block.
// Assumes nothing of its surroundings.
package dma_pkg;
  typedef enum logic [0:0] {ENG_IDLE, ENG_SERVING} engine_state_t;
  typedef logic [1:0] chan_t;
endpackage : dma_pkg

// *** include/mode_store_if.sv ***
// Link between the register block and the channel mode store.
// Assumes one clock; every strobe is a one-cycle pulse.
`timescale 1ns/1ps
interface mode_store_if;
  logic wr;
  logic [7:0] wr_data;
  logic rd_advance;
  logic clr_cnt;
  logic [7:0] rd_data;
  logic [3:0] autoinit;
  modport owner (output wr, output wr_data, output rd_advance, output clr_cnt,
    input rd_data, input autoinit);
  modport store (input wr, input wr_data, input rd_advance, input clr_cnt,
    output rd_data, output autoinit);
endinterface : mode_store_if

// *** hw/mode_store.sv ***
// Four channel mode registers behind one shared location, with readback
// counter. Assumes strobes from logic on sys_clk.
`timescale 1ns/1ps
`include "dma_regs_defs.svh"
module mode_store
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic master_clear,
  // Owner side
  mode_store_if.store ms
);
  logic [5:0] mode_ff [4];
  logic [1:0] rd_cnt_ff;
  logic [7:0] rd_data_ff;

  // ****************************************************************
  // Mode registers, selected by the two low bits of the write data
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
        mode_ff[i] <= 6'h00;
    end
    else if (ms.wr)
    begin
      mode_ff[ms.wr_data[`SEL_MSB:`SEL_LSB]] <= ms.wr_data[7:2];
    end
  end

  // ****************************************************************
  // Readback counter
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || master_clear || ms.clr_cnt)
      rd_cnt_ff <= 2'h0;
    else if (ms.rd_advance)
      rd_cnt_ff <= rd_cnt_ff + 2'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rd_data_ff <= 8'h03;
    else
      rd_data_ff <= {mode_ff[rd_cnt_ff], 2'h3};
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ai
      assign ms.autoinit[g] = mode_ff[g][`MODE_AUTOINIT_BIT - 2];
    end
  endgenerate
  assign ms.rd_data = rd_data_ff;
endmodule : mode_store

// *** test/dma_regs_monitor.sv ***
// Concurrent checks on the ports of the DMA request, mask and status block.
// Assumes the host holds address and data stable around every strobe.
`timescale 1ns/1ps
`include "dma_regs_defs.svh"
module dma_regs_monitor
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host I/O port
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic [`ADDR_W-1:0] io_addr,
  input wire logic [7:0] peripheral_data_bus_out,
  input wire logic peripheral_data_bus_oe,
  // Requests and engine view
  input wire logic [3:0] ext_request,
  input wire logic m2m_second_cycle,
  input wire logic [3:0] channel_service_request,
  input wire logic service_active,
  input wire logic byte_high,
  input wire logic master_clear_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence rd_at(a);
    $fell(io_read_strobe_n) && io_addr == a;
  endsequence
  sequence wr_at(a);
    $fell(io_write_strobe_n) && io_addr == a;
  endsequence
  sequence drive_hi(m, v);
    ##[3:6] peripheral_data_bus_oe && (peripheral_data_bus_out & m) == v;
  endsequence
  AST_RESET_IDLE: assert property ($fell(sys_rst) |-> !service_active && !byte_high)
    else $error("Engine not idle after reset");
  AST_REQ_READ: assert property (rd_at(`OFS_SOFT_REQUEST) |-> drive_hi(8'hF0, 8'hF0))
    else $error("Request readback upper bits not ones");
  AST_MODE_READ: assert property (rd_at(`OFS_MODE) |-> drive_hi(8'h03, 8'h03))
    else $error("Mode readback select bits not ones");
  AST_CMD_READ: assert property ($fell(io_read_strobe_n) && io_addr >= `OFS_CLR_BYTE_PTR
    && io_addr <= `OFS_CLR_MODE_CNT |-> drive_hi(8'hFF, 8'hFF))
    else $error("Command read data not all ones");
  AST_CLR_PTR: assert property (rd_at(`OFS_CLR_BYTE_PTR) |-> ##[3:6] !byte_high)
    else $error("Byte pointer not cleared");
  AST_SET_PTR: assert property (wr_at(`OFS_SET_BYTE_PTR) |-> ##[3:6] byte_high)
    else $error("Byte pointer not set");
  AST_PTR_TOGGLE: assert property (($fell(io_read_strobe_n) || $fell(io_write_strobe_n))
    && io_addr <= `OFS_ADDR_COUNT_LAST && !byte_high |-> ##[3:6] byte_high)
    else $error("Byte pointer did not toggle");
  AST_M2M_DRIVE: assert property (m2m_second_cycle |=> peripheral_data_bus_oe)
    else $error("Temporary data not driven");
  AST_CLR_MASK: assert property (wr_at(`OFS_CLR_MASK)
    |-> ##[5:8] (channel_service_request & ext_request) == ext_request)
    else $error("Requests still masked after clear mask");
  AST_MCLR_MASK: assert property (master_clear_pulse
    |-> ##[1:3] channel_service_request == 4'h0 && !service_active)
    else $error("Requests not masked after master clear");
  AST_MCLR_ONCE: assert property (master_clear_pulse |=> !master_clear_pulse)
    else $error("Master clear pulse too long");
endmodule : dma_regs_monitor

bind dma_request_mask_status_cmds dma_regs_monitor u_monitor (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .io_addr(io_addr),
  .peripheral_data_bus_out(peripheral_data_bus_out),
  .peripheral_data_bus_oe(peripheral_data_bus_oe), .ext_request(ext_request),
  .m2m_second_cycle(m2m_second_cycle), .channel_service_request(channel_service_request),
  .service_active(service_active), .byte_high(byte_high),
  .master_clear_pulse(master_clear_pulse));

// *** test/io_host_model.sv ***
// Host processor model issuing I/O reads and writes to the DMA block.
// Assumes the bench resolves the data wire from both drivers.
`timescale 1ns/1ps
`include "dma_regs_defs.svh"
module io_host_model
(
  // Clock and data wire
  input wire logic sys_clk,
  input wire logic [7:0] bus_wire,
  // Host drive
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic [`ADDR_W-1:0] io_addr,
  output logic [7:0] host_data
);
  initial
  begin
    io_read_strobe_n = 1'b1;
    io_write_strobe_n = 1'b1;
    io_addr = 5'h00;
    host_data = 8'h00;
  end

  // Address and data settle three cycles before the strobe, which is held six cycles.
  task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge sys_clk);
    io_addr = a;
    host_data = d;
    repeat (3) @(negedge sys_clk);
    if (rd)
      io_read_strobe_n = 1'b0;
    else
      io_write_strobe_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    q = bus_wire;
    io_read_strobe_n = 1'b1;
    io_write_strobe_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    host_data = ~host_data;
  endtask : access

  task automatic set_bus(input logic [7:0] d);
    host_data = d;
  endtask : set_bus
endmodule : io_host_model

// *** test/tb_dma_request_mask_status_cmds.sv ***
// Self-checking bench for the DMA request, mask and status block.
// Assumes the host model and the checker bound to the block.
`timescale 1ns/1ps
`include "dma_regs_defs.svh"
module tb_dma_request_mask_status_cmds;
  logic sys_clk, sys_rst, rd_n, wr_n, m2m_a, m2m_b, data_oe, svc_act, byte_high, mclr;
  logic [4:0] io_addr;
  logic [7:0] host_data, data_out, bus_wire, q;
  logic [3:0] ext_req, tc, svc_req;
  logic [1:0] svc_ch;
  int n_errors, samples_checked;
  assign bus_wire = data_oe ? data_out : host_data;

  dma_request_mask_status_cmds u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n), .io_addr(io_addr),
    .peripheral_data_bus_in(bus_wire), .peripheral_data_bus_out(data_out),
    .peripheral_data_bus_oe(data_oe), .ext_request(ext_req), .terminal_count(tc),
    .m2m_first_cycle(m2m_a), .m2m_second_cycle(m2m_b), .channel_service_request(svc_req),
    .service_active(svc_act), .service_channel(svc_ch), .byte_high(byte_high),
    .master_clear_pulse(mclr));
  io_host_model u_host (.sys_clk(sys_clk), .bus_wire(bus_wire), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .io_addr(io_addr), .host_data(host_data));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    u_host.access(1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask : rd

  task automatic pulse(input logic [3:0] t, input logic first, input logic second);
    @(negedge sys_clk);
    tc = t;
    m2m_a = first;
    m2m_b = second;
    @(negedge sys_clk);
    tc = 4'h0;
    m2m_a = 1'b0;
    m2m_b = 1'b0;
  endtask : pulse

  task automatic test_masks;
    rd(`OFS_MASK_ALL, 8'hFF);
    rd(`OFS_SOFT_REQUEST, 8'hF0);
    rd(`OFS_STATUS, 8'h00);
    wr(`OFS_MASK_ALL, 8'hF0);
    rd(`OFS_MASK_ALL, 8'hF0);
    wr(`OFS_MASK_SINGLE, 8'hFE);
    rd(`OFS_MASK_ALL, 8'hF4);
    wr(`OFS_MASK_ALL, 8'h0F);
    wr(`OFS_MASK_SINGLE, 8'hFA);
    rd(`OFS_MASK_ALL, 8'hFB);
    wr(`OFS_CLR_MASK, 8'h0F);
    rd(`OFS_MASK_ALL, 8'hF0);
  endtask : test_masks

  task automatic test_requests;
    @(negedge sys_clk);
    ext_req = 4'h5;
    wr(`OFS_MASK_ALL, 8'h0F);
    chk({4'h0, svc_req}, 8'h00);
    rd(`OFS_STATUS, 8'h50);
    wr(`OFS_CLR_MASK, 8'h00);
    chk({4'h0, svc_req}, 8'h05);
    ext_req = 4'h0;
    rd(`OFS_STATUS, 8'h00);
  endtask : test_requests

  task automatic test_soft_tc;
    wr(`OFS_MODE, 8'h44);
    wr(`OFS_MODE, 8'h89);
    wr(`OFS_MODE, 8'h12);
    wr(`OFS_MODE, 8'hC3);
    wr(`OFS_MASK_ALL, 8'h0F);
    wr(`OFS_SOFT_REQUEST, 8'hFF);
    rd(`OFS_SOFT_REQUEST, 8'hF8);
    chk({4'h0, svc_req}, 8'h08);
    wr(`OFS_MASK_ALL, 8'h00);
    pulse(4'hC, 1'b0, 1'b0);
    rd(`OFS_MASK_ALL, 8'hF8);
    rd(`OFS_STATUS, 8'h0C);
    rd(`OFS_STATUS, 8'h00);
  endtask : test_soft_tc

  task automatic test_modes;
    logic [7:0] exp [4] = '{8'h47, 8'h8B, 8'h13, 8'hC3};
    wr(`OFS_CLR_MODE_CNT, 8'h00);
    for (int i = 0; i < 4; i++)
      rd(`OFS_MODE, exp[i]);
    rd(`OFS_CLR_MODE_CNT, 8'hFF);
    rd(`OFS_MODE, 8'h47);
  endtask : test_modes

  task automatic test_byte_ptr;
    wr(`OFS_SET_BYTE_PTR, 8'h00);
    chk({7'h0, byte_high}, 8'h01);
    rd(`OFS_CLR_BYTE_PTR, 8'hFF);
    chk({7'h0, byte_high}, 8'h00);
    wr(5'h03, 8'h12);
    chk({7'h0, byte_high}, 8'h01);
    rd(5'h07, 8'hFF);
    chk({7'h0, byte_high}, 8'h00);
  endtask : test_byte_ptr

  task automatic temp_out(input logic [7:0] exp);
    pulse(4'h0, 1'b0, 1'b1);
    chk(data_oe ? data_out : 8'h00, exp);
  endtask : temp_out

  task automatic test_temp_and_clear;
    u_host.set_bus(8'hA5);
    repeat (4) @(negedge sys_clk);
    pulse(4'h0, 1'b1, 1'b0);
    u_host.set_bus(8'h3C);
    repeat (4) @(negedge sys_clk);
    temp_out(8'hA5);
    rd(`OFS_STATUS, 8'h00);
    temp_out(8'hA5);
    wr(`OFS_SOFT_REQUEST, 8'h05);
    wr(`OFS_SET_BYTE_PTR, 8'h00);
    pulse(4'h2, 1'b0, 1'b0);
    chk({7'h0, svc_act}, 8'h01);
    wr(`OFS_MASTER_CLEAR, 8'h5A);
    chk({6'h0, svc_act, byte_high}, 8'h00);
    rd(`OFS_MASK_ALL, 8'hFF);
    rd(`OFS_SOFT_REQUEST, 8'hF0);
    rd(`OFS_STATUS, 8'h00);
    temp_out(8'h00);
    wr(`OFS_SOFT_REQUEST, 8'h06);
    chk({5'h0, svc_act, svc_ch}, 8'h06);
    pulse(4'h4, 1'b0, 1'b0);
    rd(`OFS_STATUS, 8'h04);
  endtask : test_temp_and_clear

  task automatic complete_run;
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    sys_rst = 1'b1;
    ext_req = 4'h0;
    tc = 4'h0;
    m2m_a = 1'b0;
    m2m_b = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    test_masks();
    test_requests();
    test_soft_tc();
    test_modes();
    test_byte_ptr();
    test_temp_and_clear();
    complete_run();
  end
endmodule : tb_dma_request_mask_status_cmds
